// [core/mps_pkg.sv]
`default_nettype none
package mps_pkg;
	localparam int CLK_PERIOD_NS = 25;
	// half periods of the mii clocks at 10 and 100 Mb/s
	localparam int LINK10_HALF_NS = 200;
	localparam int LINK100_HALF_NS = 20;
	localparam int LINK10_HALF_CYC = (LINK10_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : LINK10_HALF_NS / CLK_PERIOD_NS;
	localparam int LINK100_HALF_CYC = (LINK100_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : LINK100_HALF_NS / CLK_PERIOD_NS;
	localparam logic [3:0] DIV10_TOP = 4'(LINK10_HALF_CYC - 1);
	localparam logic [3:0] DIV100_TOP = 4'(LINK100_HALF_CYC - 1);
	// management clock half period made by the station end
	localparam int MDC_HALF_NS = 200;
	localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] MDC_TOP = 4'(MDC_HALF_CYC - 1);
	// heartbeat test: delay after end of transmit, then pulse length
	localparam int HB_DELAY_NS = 1000;
	localparam int HB_LEN_NS = 1000;
	localparam int HB_DELAY_CYC = (HB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HB_LEN_CYC = (HB_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] HB_START = 8'(HB_DELAY_CYC + HB_LEN_CYC);
	localparam logic [7:0] HB_LEN = 8'(HB_LEN_CYC);
	// management frame layout
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0b;
	localparam logic [4:0] BODY_LAST = 5'h11;
	localparam logic [6:0] TA_BIT = 7'h2e;
	localparam logic [6:0] DATA_BIT = 7'h30;
	localparam logic [6:0] FRAME_LAST = 7'h3f;
	localparam logic [1:0] ST_CODE = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [4:0] HB_REG_ADDR = 5'h12;
	localparam int HB_SUPPRESS_BIT = 2;
	localparam logic [15:0] HB_REG_RESET = 16'h0000;
	typedef enum logic [1:0] {
		MPS_MD_IDLE = 2'b00,
		MPS_MD_START = 2'b01,
		MPS_MD_HDR = 2'b10,
		MPS_MD_BODY = 2'b11
	} mps_md_state_type;
endpackage
`default_nettype wire

// [core/mps_mii_if.sv]
`default_nettype none
interface mps_mii_if;
	logic col;
	logic crs;
	logic rxClk;
	logic txClk;
	logic [3:0] rxData;
	logic rxValid;
	logic rxError;
	logic txEn;
	logic mdc;
	logic mdioStaOut;
	logic mdioStaOe;
	logic mdioPhyOut;
	logic mdioPhyOe;
	logic mdio;
	// pull-up holds the line high when nobody drives
	assign mdio = mdioStaOe ? mdioStaOut : (mdioPhyOe ? mdioPhyOut : 1'b1);
	modport phy(output col, crs, rxClk, txClk, rxData, rxValid, rxError, mdioPhyOut, mdioPhyOe,
		input txEn, mdc, mdio);
	modport sta(input col, crs, rxClk, txClk, rxData, rxValid, rxError, mdio,
		output txEn, mdc, mdioStaOut, mdioStaOe);
endinterface
`default_nettype wire

// [core/mps_phy_end.sv]
`default_nettype none
module mps_phy_end
	import mps_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clockEnable,
	mps_mii_if.phy mii,
	input wire logic speed100,
	input wire logic fullDuplex,
	input wire logic repeaterMode,
	input wire logic [4:0] phyAddress,
	input wire logic rxUnsquelched,
	input wire logic [9:0] rxSymbol,
	input wire logic rxSymbolValid,
	input wire logic streamStart,
	input wire logic streamEnd,
	input wire logic symbolError,
	input wire logic rxValid10,
	input wire logic [3:0] rxNibbleIn,
	input wire logic rxErrorIn,
	output logic heartbeatTestSuppress
);

	function automatic logic spreadZeros(input logic [9:0] s);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 10; i++) begin
			for (int j = i + 2; j < 10; j++) begin
				if (!s[i] && !s[j]) begin
					r = 1'b1;
				end
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [3:0] divCnt, next_divCnt;
	logic linkClk, next_linkClk;
	logic [3:0] rxData, next_rxData;
	logic rxDv, next_rxDv;
	logic rxEr, next_rxEr;
	logic dvState, next_dvState;
	logic symActive, next_symActive;
	logic col, next_col;
	logic crs, next_crs;
	logic txEnPrev, next_txEnPrev;
	logic [7:0] hbCnt, next_hbCnt;
	logic [15:0] mgmtReg, next_mgmtReg;
	logic [3:0] divTop;
	logic rxUpdate;
	logic rxActivity;
	logic hbPulse;

	always_comb begin
		next_divCnt = divCnt + 4'h1;
		next_linkClk = linkClk;
		next_rxData = rxData;
		next_rxDv = rxDv;
		next_rxEr = rxEr;
		next_dvState = dvState;
		next_symActive = symActive;
		next_hbCnt = hbCnt;
		next_txEnPrev = mii.txEn;
		divTop = speed100 ? DIV100_TOP : DIV10_TOP;
		rxUpdate = 1'b0;
		if (divCnt >= divTop) begin
			next_divCnt = 4'h0;
			next_linkClk = !linkClk;
			rxUpdate = linkClk;
		end
		if (rxSymbolValid) begin
			next_symActive = spreadZeros(rxSymbol);
		end
		rxActivity = speed100 ? symActive : rxUnsquelched;
		// error and end win over a start seen in the same cycle
		if (!speed100 || streamEnd || symbolError) begin
			next_dvState = 1'b0;
		end else if (streamStart) begin
			next_dvState = 1'b1;
		end
		// updates at the falling edge, so data is steady at the rising one
		if (rxUpdate) begin
			next_rxData = rxNibbleIn;
			next_rxDv = speed100 ? dvState : rxValid10;
			next_rxEr = speed100 && rxErrorIn;
		end
		if (txEnPrev && !mii.txEn && !fullDuplex) begin
			next_hbCnt = HB_START;
		end else if (hbCnt != 8'h00) begin
			next_hbCnt = hbCnt - 8'h01;
		end
		hbPulse = (hbCnt != 8'h00) && (hbCnt <= HB_LEN);
		// no relation to the mii clocks; the mac must synchronise
		next_col = !fullDuplex && ((rxActivity && mii.txEn) || (hbPulse && !mgmtReg[HB_SUPPRESS_BIT]));
		next_crs = rxActivity || (!fullDuplex && !repeaterMode && mii.txEn);
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			divCnt <= 4'h0;
			linkClk <= 1'b0;
			rxData <= 4'h0;
			rxDv <= 1'b0;
			rxEr <= 1'b0;
			dvState <= 1'b0;
			symActive <= 1'b0;
			col <= 1'b0;
			crs <= 1'b0;
			txEnPrev <= 1'b0;
			hbCnt <= 8'h00;
		end else if (clockEnable) begin
			divCnt <= next_divCnt;
			linkClk <= next_linkClk;
			rxData <= next_rxData;
			rxDv <= next_rxDv;
			rxEr <= next_rxEr;
			dvState <= next_dvState;
			symActive <= next_symActive;
			col <= next_col;
			crs <= next_crs;
			txEnPrev <= next_txEnPrev;
			hbCnt <= next_hbCnt;
		end
	end

	assign mii.rxClk = linkClk;
	assign mii.txClk = linkClk;
	assign mii.rxData = rxData;
	assign mii.rxValid = rxDv;
	assign mii.rxError = rxEr;
	assign mii.col = col;
	assign mii.crs = crs;

	////////////////////////////////////////////////////////////////////////////////
	logic mdcS1, mdcS2, mdcS3;
	logic mdioS1, mdioS2;
	mps_md_state_type mdState, next_mdState;
	logic [5:0] preCnt, next_preCnt;
	logic [4:0] bitCnt, next_bitCnt;
	logic [11:0] hdr, next_hdr;
	logic [17:0] body, next_body;
	logic [16:0] drv, next_drv;
	logic oe, next_oe;
	logic reading, next_reading;
	logic mdcRise;
	logic [11:0] hdrFull;
	logic [17:0] bodyFull;

	always_comb begin
		next_mdState = mdState;
		next_preCnt = preCnt;
		next_bitCnt = bitCnt;
		next_hdr = hdr;
		next_body = body;
		next_drv = drv;
		next_oe = oe;
		next_reading = reading;
		next_mgmtReg = mgmtReg;
		mdcRise = mdcS2 && !mdcS3;
		hdrFull = {hdr[10:0], mdioS2};
		bodyFull = {body[16:0], mdioS2};
		if (mdcRise) begin
			case (mdState)
				MPS_MD_IDLE: begin
					if (mdioS2) begin
						next_preCnt = (preCnt == PREAMBLE_LEN) ? preCnt : preCnt + 6'h01;
					end else begin
						next_preCnt = 6'h00;
						if (preCnt == PREAMBLE_LEN) begin
							next_mdState = MPS_MD_START;
						end
					end
				end
				MPS_MD_START: begin
					next_mdState = mdioS2 ? MPS_MD_HDR : MPS_MD_IDLE;
					next_bitCnt = 5'h00;
				end
				MPS_MD_HDR: begin
					next_hdr = hdrFull;
					next_bitCnt = bitCnt + 5'h01;
					if (bitCnt == HDR_LAST) begin
						next_mdState = MPS_MD_BODY;
						next_bitCnt = 5'h00;
						next_reading = (hdrFull[11:10] == OP_READ) && (hdrFull[9:5] == phyAddress);
						next_drv = {1'b0, (hdrFull[4:0] == HB_REG_ADDR) ? mgmtReg : 16'h0000};
					end
				end
				MPS_MD_BODY: begin
					next_body = bodyFull;
					next_bitCnt = bitCnt + 5'h01;
					if (bitCnt == BODY_LAST) begin
						// driver released after the last data bit
						next_oe = 1'b0;
						next_reading = 1'b0;
						next_mdState = MPS_MD_IDLE;
						next_preCnt = 6'h00;
						if (hdr[11:10] == OP_WRITE && hdr[9:5] == phyAddress && hdr[4:0] == HB_REG_ADDR) begin
							next_mgmtReg = bodyFull[15:0];
						end
					end else if (reading) begin
						// second turnaround bit, then status bits msb first
						next_oe = 1'b1;
						if (oe) begin
							next_drv = {drv[15:0], 1'b0};
						end
					end
				end
				default: begin
					next_mdState = MPS_MD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mdcS1 <= 1'b0;
			mdcS2 <= 1'b0;
			mdcS3 <= 1'b0;
			mdioS1 <= 1'b1;
			mdioS2 <= 1'b1;
			mdState <= MPS_MD_IDLE;
			preCnt <= 6'h00;
			bitCnt <= 5'h00;
			hdr <= 12'h000;
			body <= 18'h00000;
			drv <= 17'h00000;
			oe <= 1'b0;
			reading <= 1'b0;
			mgmtReg <= HB_REG_RESET;
		end else if (clockEnable) begin
			mdcS1 <= mii.mdc;
			mdcS2 <= mdcS1;
			mdcS3 <= mdcS2;
			mdioS1 <= mii.mdio;
			mdioS2 <= mdioS1;
			mdState <= next_mdState;
			preCnt <= next_preCnt;
			bitCnt <= next_bitCnt;
			hdr <= next_hdr;
			body <= next_body;
			drv <= next_drv;
			oe <= next_oe;
			reading <= next_reading;
			mgmtReg <= next_mgmtReg;
		end
	end

	assign mii.mdioPhyOut = drv[16];
	assign mii.mdioPhyOe = oe;
	assign heartbeatTestSuppress = mgmtReg[HB_SUPPRESS_BIT];

endmodule
`default_nettype wire

// [core/mps_sta_end.sv]
`default_nettype none
module mps_sta_end
	import mps_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clockEnable,
	mps_mii_if.sta mii,
	input wire logic mgmtStart,
	input wire logic mgmtWrite,
	input wire logic [4:0] mgmtPhy,
	input wire logic [4:0] mgmtAddr,
	input wire logic [15:0] mgmtWriteData,
	output logic mgmtBusy,
	output logic mgmtDone,
	output logic [15:0] mgmtReadData,
	input wire logic txRequest,
	output logic collision,
	output logic carrierSense,
	output logic [3:0] rxData,
	output logic rxValid,
	output logic rxError,
	output logic rxStrobe
);

	////////////////////////////////////////////////////////////////////////////////
	// every mii input is foreign: two flops before use
	logic colS1, crsS1, rxcS1, rxcS2, rxcS3, txcS1, txcS2, txcS3;
	logic [5:0] rxS1, rxS2;
	logic txEn, next_txEn;
	logic [5:0] rxQ, next_rxQ;
	logic strobe, next_strobe;

	always_comb begin
		next_txEn = txEn;
		next_rxQ = rxQ;
		next_strobe = 1'b0;
		if (txcS2 && !txcS3) begin
			next_txEn = txRequest;
		end
		if (rxcS2 && !rxcS3) begin
			next_rxQ = rxS2;
			next_strobe = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			{colS1, crsS1, collision, carrierSense} <= 4'h0;
			{rxcS1, rxcS2, rxcS3, txcS1, txcS2, txcS3} <= 6'h00;
			rxS1 <= 6'h00;
			rxS2 <= 6'h00;
			txEn <= 1'b0;
			rxQ <= 6'h00;
			strobe <= 1'b0;
		end else if (clockEnable) begin
			colS1 <= mii.col;
			collision <= colS1;
			crsS1 <= mii.crs;
			carrierSense <= crsS1;
			rxcS1 <= mii.rxClk;
			rxcS2 <= rxcS1;
			rxcS3 <= rxcS2;
			txcS1 <= mii.txClk;
			txcS2 <= txcS1;
			txcS3 <= txcS2;
			rxS1 <= {mii.rxError, mii.rxValid, mii.rxData};
			rxS2 <= rxS1;
			txEn <= next_txEn;
			rxQ <= next_rxQ;
			strobe <= next_strobe;
		end
	end

	assign mii.txEn = txEn;
	assign rxData = rxQ[3:0];
	assign rxValid = rxQ[4];
	assign rxError = rxQ[5];
	assign rxStrobe = strobe;

	////////////////////////////////////////////////////////////////////////////////
	logic mdioS1, mdioS2;
	logic busy, next_busy;
	logic done, next_done;
	logic isWrite, next_isWrite;
	logic [3:0] mdcCnt, next_mdcCnt;
	logic mdc, next_mdc;
	logic [6:0] bitIdx, next_bitIdx;
	logic [63:0] frame, next_frame;
	logic out, next_out;
	logic oe, next_oe;
	logic [15:0] rdShift, next_rdShift;
	logic [15:0] rdData, next_rdData;

	always_comb begin
		next_busy = busy;
		next_done = 1'b0;
		next_isWrite = isWrite;
		next_mdcCnt = mdcCnt;
		next_mdc = mdc;
		next_bitIdx = bitIdx;
		next_frame = frame;
		next_out = out;
		next_oe = oe;
		next_rdShift = rdShift;
		next_rdData = rdData;
		if (!busy) begin
			if (mgmtStart) begin
				next_busy = 1'b1;
				next_isWrite = mgmtWrite;
				next_mdcCnt = 4'h0;
				next_bitIdx = 7'h00;
				next_frame = {32'hffffffff, ST_CODE, mgmtWrite ? OP_WRITE : OP_READ, mgmtPhy, mgmtAddr,
					2'h2, mgmtWrite ? mgmtWriteData : 16'hffff};
				next_out = 1'b1;
				next_oe = 1'b1;
			end
		end else if (mdcCnt == MDC_TOP) begin
			next_mdcCnt = 4'h0;
			next_mdc = !mdc;
			if (!mdc) begin
				// sample on the rising edge, phy drove it a full period earlier
				if (!isWrite && bitIdx >= DATA_BIT) begin
					next_rdShift = {rdShift[14:0], mdioS2};
				end
			end else if (bitIdx == FRAME_LAST) begin
				next_busy = 1'b0;
				next_done = 1'b1;
				next_oe = 1'b0;
				next_rdData = isWrite ? rdData : rdShift;
			end else begin
				// change on the falling edge, steady at the next rising
				next_bitIdx = bitIdx + 7'h01;
				next_frame = {frame[62:0], 1'b1};
				next_out = frame[62];
				next_oe = isWrite || (bitIdx + 7'h01 < TA_BIT);
			end
		end else begin
			next_mdcCnt = mdcCnt + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mdioS1 <= 1'b1;
			mdioS2 <= 1'b1;
			busy <= 1'b0;
			done <= 1'b0;
			isWrite <= 1'b0;
			mdcCnt <= 4'h0;
			mdc <= 1'b0;
			bitIdx <= 7'h00;
			frame <= 64'h0;
			out <= 1'b1;
			oe <= 1'b0;
			rdShift <= 16'h0000;
			rdData <= 16'h0000;
		end else if (clockEnable) begin
			mdioS1 <= mii.mdio;
			mdioS2 <= mdioS1;
			busy <= next_busy;
			done <= next_done;
			isWrite <= next_isWrite;
			mdcCnt <= next_mdcCnt;
			mdc <= next_mdc;
			bitIdx <= next_bitIdx;
			frame <= next_frame;
			out <= next_out;
			oe <= next_oe;
			rdShift <= next_rdShift;
			rdData <= next_rdData;
		end
	end

	assign mii.mdc = mdc;
	assign mii.mdioStaOut = out;
	assign mii.mdioStaOe = oe;
	assign mgmtBusy = busy;
	assign mgmtDone = done;
	assign mgmtReadData = rdData;

endmodule
`default_nettype wire

// [sim/mps_checker_sva.sv]
`default_nettype none
module mps_checker_sva (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic col,
	input wire logic crs,
	input wire logic rxClk,
	input wire logic txClk,
	input wire logic [3:0] rxData,
	input wire logic rxValid,
	input wire logic rxError,
	input wire logic txEn,
	input wire logic mdc,
	input wire logic mdioStaOe,
	input wire logic mdioPhyOe,
	input wire logic speed100,
	input wire logic fullDuplex,
	input wire logic repeaterMode,
	input wire logic rxUnsquelched,
	input wire logic heartbeatTestSuppress
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////
	a_col_on_tx: assert property (!speed100 && rxUnsquelched && txEn && !fullDuplex |=> col)
		else $error("no collision on receive during transmit");
	a_fd_col_low: assert property (fullDuplex |=> !col)
		else $error("collision in full duplex");
	a_crs_on_tx: assert property (!fullDuplex && !repeaterMode && txEn |=> crs)
		else $error("no carrier while transmitting");
	a_crs_on_rx: assert property (!speed100 && rxUnsquelched |=> crs)
		else $error("no carrier while receiving");
	a_crs_rx_only: assert property ((fullDuplex || repeaterMode) && !speed100 && !rxUnsquelched |=> !crs)
		else $error("carrier from own transmit");
	// pulse may start 40 to 43 cycles after the fall, register stages included
	a_hb_pulse: assert property ($fell(txEn) && !fullDuplex && !heartbeatTestSuppress |-> ##[40:43] col)
		else $error("heartbeat pulse missing");
	a_mdc_half: assert property ($rose(mdc) |=> mdc[*7] ##1 !mdc)
		else $error("management clock high phase wrong");
	a_phy_drive_own: assert property (mdioPhyOe |-> !mdioStaOe)
		else $error("both ends drive management line");
	a_phy_oe_mdc: assert property ($changed(mdioPhyOe) |-> mdc)
		else $error("phy driver switched outside clock high");
	a_rx_on_fall: assert property (!$stable({rxData, rxValid, rxError}) |-> $fell(rxClk))
		else $error("receive outputs moved off clock fall");
	// clocks are checked only once reset and speed have been steady a few cycles
	a_clk_100m: assert property (speed100 && $past(speed100, 3) && $past(reset_n, 3) |-> $changed(txClk) && rxClk == txClk)
		else $error("fast link clock not toggling");
	// a speed change may cut the last slow high phase short
	a_clk_10m: assert property (!speed100 && $rose(txClk) |=> (txClk || speed100)[*7])
		else $error("slow link clock high phase wrong");
endmodule
`default_nettype wire

// [sim/tb_mii_phy_status_and_mgmt_pins.sv]
`default_nettype none
module tb_mii_phy_status_and_mgmt_pins
	import mps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clockEnable = 1'b1;
	logic speed100 = 1'b0, fullDuplex = 1'b0, repeaterMode = 1'b0, rxUnsquelched = 1'b0, rxValid10 = 1'b0;
	logic rxSymbolValid = 1'b0, streamStart = 1'b0, streamEnd = 1'b0, symbolError = 1'b0, rxErrorIn = 1'b0;
	logic mgmtStart = 1'b0, mgmtWrite = 1'b0, txRequest = 1'b0, hbSeen;
	logic [9:0] rxSymbol = 10'h3ff;
	logic [3:0] rxNibbleIn = 4'h0, rxData;
	logic [4:0] phyAddress = 5'h01, mgmtPhy = 5'h01, mgmtAddr = 5'h00;
	logic [15:0] mgmtWriteData = 16'h0000, mgmtReadData;
	logic heartbeatTestSuppress, mgmtBusy, mgmtDone, collision, carrierSense, rxValid, rxError, rxStrobe;
	int miscompares = 0;
	int nChecks = 0;
	// duplex, repeater, receive, transmit -> collision, carrier
	logic [5:0] rows [8] = '{6'h00, 6'h09, 6'h05, 6'h0f, 6'h24, 6'h2d, 6'h14, 6'h1f};
	logic [9:0] symbols [4] = '{10'h3f5, 10'h3f3, 10'h1fe, 10'h1ff};
	logic [3:0] symbolAct = 4'h5;
	// start, end, error pulses; end beats start, error ends a valid stream
	logic [2:0] delims [4] = '{3'h4, 3'h6, 3'h4, 3'h1};
	logic [3:0] delimValid = 4'h5;
	mps_mii_if mii();
	mps_phy_end mps_phy_end_i (.clock, .reset_n, .clockEnable, .mii(mii.phy), .speed100, .fullDuplex, .repeaterMode,
		.phyAddress, .rxUnsquelched, .rxSymbol, .rxSymbolValid, .streamStart, .streamEnd, .symbolError, .rxValid10,
		.rxNibbleIn, .rxErrorIn, .heartbeatTestSuppress);
	mps_sta_end mps_sta_end_i (.clock, .reset_n, .clockEnable, .mii(mii.sta), .mgmtStart, .mgmtWrite, .mgmtPhy,
		.mgmtAddr, .mgmtWriteData, .mgmtBusy, .mgmtDone, .mgmtReadData, .txRequest, .collision, .carrierSense,
		.rxData, .rxValid, .rxError, .rxStrobe);
	mps_checker_sva mps_checker_sva_i (.clock, .reset_n, .col(mii.col), .crs(mii.crs), .rxClk(mii.rxClk),
		.txClk(mii.txClk), .rxData(mii.rxData), .rxValid(mii.rxValid), .rxError(mii.rxError), .txEn(mii.txEn),
		.mdc(mii.mdc), .mdioStaOe(mii.mdioStaOe), .mdioPhyOe(mii.mdioPhyOe), .speed100, .fullDuplex,
		.repeaterMode, .rxUnsquelched, .heartbeatTestSuppress);
	always #12.5 clock = ~clock;
	////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic check(input string name, input logic [15:0] want, input logic [15:0] seen);
		nChecks++;
		if (seen !== want) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic complete_run;
		if (miscompares == 0 && nChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// bounded wait on receive strobe or management done
	task automatic waitFor(input bit strobe);
		int n;
		n = 0;
		while ((strobe ? rxStrobe : mgmtDone) !== 1'b1) begin
			tick(1);
			n++;
			if (n > 1500) begin
				miscompares++;
				complete_run();
			end
		end
	endtask
	task automatic mgmt(input logic wr, input logic [4:0] phy, input logic [4:0] addr, input logic [15:0] data);
		mgmtWrite = wr;
		mgmtPhy = phy;
		mgmtAddr = addr;
		mgmtWriteData = data;
		mgmtStart = 1'b1;
		tick(1);
		mgmtStart = 1'b0;
		waitFor(1'b0);
		tick(1);
	endtask
	task automatic hbRun(input logic want);
		txRequest = 1'b1;
		tick(40);
		txRequest = 1'b0;
		hbSeen = 1'b0;
		repeat (150) begin
			tick(1);
			hbSeen = hbSeen | collision;
		end
		check("heartbeat", 16'(want), 16'(hbSeen));
	endtask
	// first strobe may still carry older data, so settle first
	task automatic rxCheck(input logic want, input logic [3:0] nib);
		tick(40);
		waitFor(1'b1);
		check("rx valid", 16'(want), 16'(rxValid));
		if (want) begin
			check("rx nibble", 16'(nib), 16'(rxData));
		end
	endtask
	////////////////////////////////
	initial begin
		tick(5);
		check("mdio in reset", 16'h0001, 16'(mii.mdio));
		reset_n = 1'b1;
		for (int i = 0; i < 8; i++) begin
			{fullDuplex, repeaterMode, rxUnsquelched, txRequest} = rows[i][5:2];
			tick(120);
			check("collision", 16'(rows[i][1]), 16'(collision));
			check("carrier", 16'(rows[i][0]), 16'(carrierSense));
			check("col pin", 16'(rows[i][1]), 16'(mii.col));
			check("crs pin", 16'(rows[i][0]), 16'(mii.crs));
		end
		rxUnsquelched = 1'b0;
		repeaterMode = 1'b0;
		hbRun(1'b1);
		mgmt(1'b1, phyAddress, HB_REG_ADDR, 16'h0001 << HB_SUPPRESS_BIT);
		check("suppress", 16'h0001, 16'(heartbeatTestSuppress));
		hbRun(1'b0);
		mgmt(1'b1, 5'h02, HB_REG_ADDR, 16'h0000);
		check("foreign write", 16'h0001, 16'(heartbeatTestSuppress));
		mgmt(1'b0, phyAddress, HB_REG_ADDR, 16'h0000);
		check("read back", 16'h0001 << HB_SUPPRESS_BIT, mgmtReadData);
		mgmt(1'b0, phyAddress, 5'h05, 16'h0000);
		check("other reg", 16'h0000, mgmtReadData);
		mgmt(1'b0, 5'h02, HB_REG_ADDR, 16'h0000);
		check("foreign read", 16'hffff, mgmtReadData);
		rxValid10 = 1'b1;
		rxNibbleIn = 4'ha;
		rxErrorIn = 1'b1;
		rxCheck(1'b1, 4'ha);
		check("rx error slow", 16'h0000, 16'(rxError));
		speed100 = 1'b1;
		rxValid10 = 1'b0;
		rxErrorIn = 1'b0;
		rxNibbleIn = 4'h5;
		for (int i = 0; i < 4; i++) begin
			{streamStart, streamEnd, symbolError} = delims[i];
			tick(1);
			{streamStart, streamEnd, symbolError} = 3'h0;
			rxCheck(delimValid[i], 4'h5);
		end
		rxErrorIn = 1'b1;
		rxCheck(1'b0, 4'h5);
		check("rx error fast", 16'h0001, 16'(rxError));
		rxErrorIn = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rxSymbol = symbols[i];
			rxSymbolValid = 1'b1;
			tick(1);
			rxSymbolValid = 1'b0;
			tick(10);
			check("symbol activity", 16'(symbolAct[i]), 16'(carrierSense));
		end
		// reset in mid transfer must drop the line back to the pull-up
		mgmtWrite = 1'b0;
		mgmtStart = 1'b1;
		tick(1);
		mgmtStart = 1'b0;
		tick(100);
		reset_n = 1'b0;
		tick(3);
		check("busy in reset", 16'h0000, 16'(mgmtBusy));
		check("mdio mid reset", 16'h0001, 16'(mii.mdio));
		reset_n = 1'b1;
		mgmt(1'b0, phyAddress, HB_REG_ADDR, 16'h0000);
		check("reg after reset", 16'h0000, mgmtReadData);
		complete_run();
	end
endmodule
`default_nettype wire
